// *** src/cdr_config_regs.sv ***
// coprocessor decode config bank: general register, descriptors, local decode
// assumes single-cycle side config bus strobes and decode inputs synchronous to core_clk_i
`timescale 1ns/1ps
module cdr_config_regs #(
	parameter int unsigned N = cdr_pkg::NUM_DESC
) (
	input  wire logic                        core_clk_i,
	input  wire logic                        rst_i,
	input  wire logic [31:0]                 ctl_tieoff_i,
	input  wire logic [31:0]                 desc_tieoff_i [N],
	input  wire logic [cdr_pkg::ADDR_W-1:0]  cfg_addr_i,
	input  wire logic                        cfg_rd_i,
	input  wire logic                        cfg_wr_i,
	input  wire logic [31:0]                 cfg_wdata_i,
	output logic      [31:0]                 cfg_rdata_o,
	output logic                             cfg_ack_o,
	input  wire logic                        instr_valid_i,
	input  wire logic [31:0]                 instr_i,
	input  wire logic                        instr_memop_i,
	input  wire logic                        instr_float_i,
	input  wire logic [2:0]                  float_group_i,
	input  wire logic                        instr_divide_i,
	input  wire logic                        privileged_i,
	input  wire logic [31:0]                 mem_addr_i,
	input  wire logic [2:0]                  mem_size_i,
	input  wire logic                        access_endian_flag_i,
	input  wire logic                        store_done_i,
	input  wire logic [31:0]                 coprocessor_result_i,
	output logic                             dec_valid_o,
	output logic                             dec_custom_o,
	output logic                             dec_memop_o,
	output logic                             dec_float_o,
	output logic                             dec_divide_o,
	output logic      [$clog2(N)-1:0]        dec_index_o,
	output logic      [1:0]                  dec_class_o,
	output logic                             dec_nonblocking_o,
	output logic                             priv_fault_o,
	output logic                             first_operand_needed_o,
	output logic                             second_operand_needed_o,
	output logic                             result_writeback_o,
	output logic                             overflow_return_enable_o,
	output logic                             carry_return_enable_o,
	output logic      [2:0]                  condition_field_select_o,
	output logic      [31:0]                 mem_addr_o,
	output logic                             align_exc_o,
	output logic                             commit_point_signal_o,
	output logic      [31:0]                 store_data_o
);
	localparam int unsigned IW = $clog2(N);

	function automatic logic [31:0] byte_rev(input logic [31:0] v);
		return {v[7:0], v[15:8], v[23:16], v[31:24]};
	endfunction : byte_rev

	function automatic logic [31:0] natural_align(input logic [31:0] a, input logic [2:0] sz);
		logic [31:0] low;
		low = (32'h0000_0001 << sz) - 32'h0000_0001;
		return a & ~low;
	endfunction : natural_align

	////////////////////////////////////////////////////////////////////////////
	// registers

	logic [31:0]   gen_ff;
	logic [31:0]   desc_ff [N];
	logic [IW-1:0] rd_ptr_ff;

	logic          wr_gen;
	logic          wr_desc;
	logic          rd_gen;
	logic          rd_desc;
	logic          reload;
	logic          ghost;
	logic [IW-1:0] wr_ptr;

	assign wr_gen  = cfg_wr_i && (cfg_addr_i == cdr_pkg::GEN_OFS);
	assign wr_desc = cfg_wr_i && (cfg_addr_i == cdr_pkg::DESC_OFS);
	assign rd_gen  = cfg_rd_i && (cfg_addr_i == cdr_pkg::GEN_OFS);
	assign rd_desc = cfg_rd_i && (cfg_addr_i == cdr_pkg::DESC_OFS);
	assign reload  = wr_gen && cfg_wdata_i[cdr_pkg::G_RELOAD];
	assign ghost   = cfg_wdata_i[cdr_pkg::D_CLS_HI:cdr_pkg::D_CLS_LO] == cdr_pkg::CLS_POINTER;
	assign wr_ptr  = cfg_wdata_i[cdr_pkg::D_PTR_LO +: IW];

	// reload bit self-clears, never stored
	always_ff @(posedge core_clk_i) begin
		if (rst_i || reload) begin
			gen_ff <= ctl_tieoff_i & cdr_pkg::GEN_RW_MASK;
		end else if (wr_gen) begin
			gen_ff <= cfg_wdata_i & cdr_pkg::GEN_RW_MASK;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i || reload) begin
			for (int i = 0; i < N; i++) begin
				desc_ff[i] <= desc_tieoff_i[i] & cdr_pkg::DESC_RW_MASK;
			end
		end else if (wr_desc && !ghost) begin
			desc_ff[wr_ptr] <= cfg_wdata_i & cdr_pkg::DESC_RW_MASK;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			rd_ptr_ff <= '0;
		end else if (wr_desc && ghost) begin
			rd_ptr_ff <= wr_ptr;
		end else if (rd_desc) begin
			rd_ptr_ff <= rd_ptr_ff + 1'b1;
		end
	end

	// every strobe is answered next cycle; unmapped reads return zero
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			cfg_ack_o   <= 1'b0;
			cfg_rdata_o <= 32'h0000_0000;
		end else begin
			cfg_ack_o   <= cfg_rd_i || cfg_wr_i;
			cfg_rdata_o <= rd_gen ? gen_ff : (rd_desc ? desc_ff[rd_ptr_ff] : 32'h0000_0000);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// instruction decode

	cdr_match_if #(.N(N)) mif ();

	assign mif.desc  = desc_ff;
	assign mif.instr = instr_i;

	cdr_desc_match #(.N(N)) u_match (
		.m (mif.matcher)
	);

	logic        cop_en;
	logic        custom_ok;
	logic        memop_ok;
	logic        float_ok;
	logic        divide_ok;
	logic [31:0] hit_desc;
	logic [1:0]  hit_cls;

	assign cop_en    = gen_ff[cdr_pkg::G_COP_EN];
	assign custom_ok = cop_en && mif.hit && !gen_ff[cdr_pkg::G_CUSTOM_OFF];
	assign memop_ok  = cop_en && instr_memop_i && !gen_ff[cdr_pkg::G_MEMOP_OFF] &&
		!gen_ff[cdr_pkg::G_CUSTOM_OFF];
	assign float_ok  = cop_en && instr_float_i && !gen_ff[cdr_pkg::G_FLOAT_OFF] &&
		!(|(float_group_i & gen_ff[cdr_pkg::G_FCOMPLEX_OFF -: 3]));
	assign divide_ok = cop_en && instr_divide_i && gen_ff[cdr_pkg::G_DIVIDE];
	assign hit_desc  = desc_ff[mif.idx];
	assign hit_cls   = hit_desc[cdr_pkg::D_CLS_HI:cdr_pkg::D_CLS_LO];

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			dec_valid_o  <= 1'b0;
			dec_custom_o <= 1'b0;
			dec_memop_o  <= 1'b0;
			dec_float_o  <= 1'b0;
			dec_divide_o <= 1'b0;
		end else begin
			dec_valid_o  <= instr_valid_i && (custom_ok || memop_ok || float_ok || divide_ok);
			dec_custom_o <= instr_valid_i && custom_ok;
			dec_memop_o  <= instr_valid_i && memop_ok;
			dec_float_o  <= instr_valid_i && float_ok;
			dec_divide_o <= instr_valid_i && divide_ok;
		end
	end

	// custom descriptor attributes, held from the matching descriptor
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			dec_index_o              <= '0;
			dec_class_o              <= cdr_pkg::CLS_BLOCKING;
			first_operand_needed_o   <= 1'b0;
			second_operand_needed_o  <= 1'b0;
			result_writeback_o       <= 1'b0;
			overflow_return_enable_o <= 1'b0;
			carry_return_enable_o    <= 1'b0;
			condition_field_select_o <= 3'h0;
		end else if (instr_valid_i && custom_ok) begin
			dec_index_o              <= mif.idx;
			dec_class_o              <= hit_cls;
			first_operand_needed_o   <= hit_desc[cdr_pkg::D_RA];
			second_operand_needed_o  <= hit_desc[cdr_pkg::D_RB];
			result_writeback_o       <= hit_desc[cdr_pkg::D_WB];
			overflow_return_enable_o <= hit_desc[cdr_pkg::D_OV];
			carry_return_enable_o    <= hit_desc[cdr_pkg::D_CA];
			condition_field_select_o <= hit_desc[cdr_pkg::D_CR_HI:cdr_pkg::D_CR_LO];
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			dec_nonblocking_o <= 1'b0;
			priv_fault_o      <= 1'b0;
		end else begin
			dec_nonblocking_o <= instr_valid_i && ((custom_ok && (hit_cls == cdr_pkg::CLS_NONBLOCKING ||
				gen_ff[cdr_pkg::G_CUSTOM_NB])) || (float_ok && gen_ff[cdr_pkg::G_FLOAT_NB]));
			priv_fault_o <= instr_valid_i && !privileged_i &&
				((custom_ok && hit_desc[cdr_pkg::D_PRIV]) ||
				(memop_ok && gen_ff[cdr_pkg::G_MEMOP_PRIV]));
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// load/store path

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			mem_addr_o  <= 32'h0000_0000;
			align_exc_o <= 1'b0;
		end else begin
			mem_addr_o  <= gen_ff[cdr_pkg::G_ALIGN] ? natural_align(mem_addr_i, mem_size_i) : mem_addr_i;
			align_exc_o <= instr_valid_i && memop_ok &&
				((gen_ff[cdr_pkg::G_LE_TRAP] && access_endian_flag_i) ||
				(gen_ff[cdr_pkg::G_BE_TRAP] && !access_endian_flag_i));
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			commit_point_signal_o <= 1'b0;
			store_data_o          <= 32'h0000_0000;
		end else begin
			commit_point_signal_o <= cop_en && gen_ff[cdr_pkg::G_STORE_COMMIT] && store_done_i;
			store_data_o <= (access_endian_flag_i && !gen_ff[cdr_pkg::G_BE_STEER]) ?
				byte_rev(coprocessor_result_i) : coprocessor_result_i;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (rst_i);

	chk_reload_general: assert property (reload |=> gen_ff == $past(ctl_tieoff_i & cdr_pkg::GEN_RW_MASK))
		else $error("general register not reloaded");
	chk_reload_desc: assert property (reload |=> desc_ff[N-1] == $past(desc_tieoff_i[N-1] & cdr_pkg::DESC_RW_MASK))
		else $error("descriptor not reloaded");
	chk_memop_off: assert property (instr_valid_i && instr_memop_i &&
		gen_ff[cdr_pkg::G_MEMOP_OFF] |=> !dec_memop_o)
		else $error("memop decoded while disabled");
	chk_custom_off: assert property (instr_valid_i && gen_ff[cdr_pkg::G_CUSTOM_OFF] |=>
		!dec_custom_o && !dec_memop_o)
		else $error("custom or memop decoded while disabled");
	chk_force_nb: assert property (dec_custom_o && $past(gen_ff[cdr_pkg::G_CUSTOM_NB]) |-> dec_nonblocking_o)
		else $error("forced custom not non-blocking");
	chk_float_off: assert property (instr_valid_i && (gen_ff[cdr_pkg::G_FLOAT_OFF] ||
		|(float_group_i & gen_ff[cdr_pkg::G_FCOMPLEX_OFF -: 3])) |=> !dec_float_o)
		else $error("float decoded while disabled");
	chk_commit_gate: assert property (commit_point_signal_o |->
		$past(gen_ff[cdr_pkg::G_STORE_COMMIT] && store_done_i))
		else $error("commit point without enable");
	chk_memop_priv: assert property (dec_memop_o && $past(gen_ff[cdr_pkg::G_MEMOP_PRIV] &&
		!privileged_i) |-> priv_fault_o)
		else $error("unprivileged memop not faulted");
	chk_word_align: assert property ($past(gen_ff[cdr_pkg::G_ALIGN]) && $past(mem_size_i) == 3'h2 &&
		!$past(rst_i) |-> mem_addr_o[1:0] == 2'h0)
		else $error("word address not aligned");
	chk_le_trap: assert property (instr_valid_i && memop_ok && gen_ff[cdr_pkg::G_LE_TRAP] &&
		access_endian_flag_i |=> align_exc_o)
		else $error("little-endian trap missing");
	chk_ptr_incr: assert property (rd_desc |=> rd_ptr_ff == $past(rd_ptr_ff) + 1'b1)
		else $error("read pointer did not advance");
	chk_ghost_write: assert property (wr_desc && ghost |=>
		rd_ptr_ff == $past(wr_ptr) && desc_ff[0] == $past(desc_ff[0]))
		else $error("pointer write disturbed descriptors");
	chk_match_enabled: assert property (dec_custom_o |-> $past(hit_desc[cdr_pkg::D_EN]))
		else $error("custom decode from disabled descriptor");
	chk_cop_gate: assert property (!cop_en |=> !dec_valid_o && !commit_point_signal_o)
		else $error("activity with coprocessor disabled");

	cov_reload: cover property (reload ##1 rd_gen);
	cov_ghost_read: cover property (wr_desc && ghost ##1 rd_desc[*2]);
	cov_custom_hit: cover property (dec_custom_o && dec_nonblocking_o);
	cov_commit: cover property (commit_point_signal_o);
endmodule : cdr_config_regs

// *** src/cdr_pkg.sv ***
// constants, field positions and types of the coprocessor decode config bank
// assumes msb-first field numbering mapped to lsb-0 indexes (field bit n -> index 31-n)
package cdr_pkg;
	localparam int unsigned NUM_DESC       = 8;
	localparam int unsigned ADDR_W         = 10;
	localparam logic [9:0]  GEN_OFS        = 10'h000;
	localparam logic [9:0]  DESC_OFS       = 10'h001;
	// general register fields
	localparam int unsigned G_RELOAD       = 31;
	localparam int unsigned G_MEMOP_OFF    = 26;
	localparam int unsigned G_CUSTOM_OFF   = 25;
	localparam int unsigned G_CUSTOM_NB    = 24;
	localparam int unsigned G_FLOAT_OFF    = 23;
	localparam int unsigned G_FCOMPLEX_OFF = 22;
	localparam int unsigned G_FLOAT_NB     = 16;
	localparam int unsigned G_STORE_COMMIT = 15;
	localparam int unsigned G_MEMOP_PRIV   = 14;
	localparam int unsigned G_ALIGN        = 11;
	localparam int unsigned G_LE_TRAP      = 10;
	localparam int unsigned G_BE_TRAP      = 9;
	localparam int unsigned G_BE_STEER     = 8;
	localparam int unsigned G_DIVIDE       = 7;
	localparam int unsigned G_COP_EN       = 0;
	localparam logic [31:0] GEN_RW_MASK    = 32'h07F1_CF81;
	// descriptor fields
	localparam int unsigned D_PRIM_SEL     = 31;
	localparam int unsigned D_EXT_HI       = 30;
	localparam int unsigned D_EXT_LO       = 20;
	localparam int unsigned D_PRIV         = 19;
	localparam int unsigned D_RA           = 18;
	localparam int unsigned D_RB           = 17;
	localparam int unsigned D_WB           = 16;
	localparam int unsigned D_OV           = 15;
	localparam int unsigned D_CA           = 14;
	localparam int unsigned D_CR_HI        = 13;
	localparam int unsigned D_CR_LO        = 11;
	localparam int unsigned D_CLS_HI       = 5;
	localparam int unsigned D_CLS_LO       = 4;
	localparam int unsigned D_PTR_HI       = 3;
	localparam int unsigned D_PTR_LO       = 1;
	localparam int unsigned D_EN           = 0;
	localparam logic [31:0] DESC_RW_MASK   = 32'hFFFF_F83F;
	localparam logic [5:0]  PRIM_OP_ZERO   = 6'h00;
	localparam logic [5:0]  PRIM_OP_FOUR   = 6'h04;
	typedef enum logic [1:0] {
		CLS_BLOCKING    = 2'h0,
		CLS_NONBLOCKING = 2'h1,
		CLS_AUTONOMOUS  = 2'h2,
		CLS_POINTER     = 2'h3
	} cdr_class_e;
endpackage : cdr_pkg

// *** src/cdr_match_if.sv ***
// descriptor table and instruction into the matcher, hit and index back
// assumes the owner drives desc and instr every cycle
`timescale 1ns/1ps
interface cdr_match_if #(parameter int unsigned N = 8);
	logic [31:0]          desc [N];
	logic [31:0]          instr;
	logic                 hit;
	logic [$clog2(N)-1:0] idx;
	modport owner (output desc, output instr, input hit, input idx);
	modport matcher (input desc, input instr, output hit, output idx);
endinterface : cdr_match_if

// *** src/cdr_desc_match.sv ***
// combinational custom instruction matcher over all descriptors
// assumes the owner registers hit and idx before they leave the block
`timescale 1ns/1ps
module cdr_desc_match #(
	parameter int unsigned N = 8
) (
	cdr_match_if.matcher m
);
	function automatic logic desc_hit(input logic [31:0] d, input logic [31:0] ins);
		logic [5:0] prim;
		prim = d[cdr_pkg::D_PRIM_SEL] ? cdr_pkg::PRIM_OP_FOUR : cdr_pkg::PRIM_OP_ZERO;
		return d[cdr_pkg::D_EN] && (ins[31:26] == prim) &&
			(ins[10:0] == d[cdr_pkg::D_EXT_HI:cdr_pkg::D_EXT_LO]);
	endfunction : desc_hit

	logic [N-1:0] hits;

	for (genvar g = 0; g < N; g++) begin : g_desc
		assign hits[g] = desc_hit(m.desc[g], m.instr);
	end

	// lowest index wins when several descriptors match
	always_comb begin
		m.hit = |hits;
		m.idx = '0;
		for (int i = N - 1; i >= 0; i--) begin
			if (hits[i]) begin
				m.idx = i[$clog2(N)-1:0];
			end
		end
	end
endmodule : cdr_desc_match

// *** src/unused_placeholder_removed.sv ***
`timescale 1ns/1ps

// *** tb/cdr_fabric_model.sv ***
// fabric coprocessor stand-in: supplies a result word that changes every cycle
// assumes the bench samples the result between rising edges of core_clk_i
`timescale 1ns/1ps
module cdr_fabric_model (
	input  wire logic        core_clk_i,
	input  wire logic        rst_i,
	input  wire logic        dec_custom_i,
	output logic      [31:0] result_o
);
	// rotating word, so a stale or settled value never matches by chance
	always_ff @(posedge core_clk_i) begin
		if (rst_i)
			result_o <= 32'h1357_9BDF;
		else
			result_o <= {result_o[30:0], result_o[31]} ^ {31'h0, dec_custom_i};
	end
endmodule : cdr_fabric_model

// *** tb/coprocessor_decode_config_regs_bench.sv ***
// self-checking bench of the coprocessor decode config bank
// assumes a one-cycle ack on the config bus and decode outputs one cycle after the request
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin err_total++; \
	$display("wrong value %s expected %h seen %h", nm, e, g); end end
module coprocessor_decode_config_regs_bench;
	localparam logic [9:0] GA = cdr_pkg::GEN_OFS;
	localparam logic [9:0] DA = cdr_pkg::DESC_OFS;
	logic core_clk_i = 1'h0, rst_i = 1'h1, cfg_rd_i = 1'h0, cfg_wr_i = 1'h0, instr_valid_i = 1'h0;
	logic instr_memop_i = 1'h0, instr_float_i = 1'h0, instr_divide_i = 1'h0, privileged_i = 1'h0;
	logic access_endian_flag_i = 1'h0, store_done_i = 1'h0;
	logic [31:0] ctl_tieoff_i = 32'hF000_0181, cfg_wdata_i = 32'h0, instr_i = 32'h0, mem_addr_i = 32'h0;
	logic [31:0] desc_tieoff_i [8];
	logic [9:0]  cfg_addr_i = 10'h0;
	logic [2:0]  float_group_i = 3'h0, mem_size_i = 3'h0, dec_index_o, condition_field_select_o;
	logic [31:0] cfg_rdata_o, coprocessor_result_i, mem_addr_o, store_data_o, cap;
	logic [1:0]  dec_class_o;
	logic cfg_ack_o, dec_valid_o, dec_custom_o, dec_memop_o, dec_float_o, dec_divide_o, dec_nonblocking_o;
	logic priv_fault_o, first_operand_needed_o, second_operand_needed_o, result_writeback_o;
	logic overflow_return_enable_o, carry_return_enable_o, align_exc_o, commit_point_signal_o;
	int err_total = 0, n_compared = 0;

	cdr_config_regs #(.N(8)) cdr_config_regs_inst (.core_clk_i, .rst_i, .ctl_tieoff_i, .desc_tieoff_i,
		.cfg_addr_i, .cfg_rd_i, .cfg_wr_i, .cfg_wdata_i, .cfg_rdata_o, .cfg_ack_o, .instr_valid_i, .instr_i,
		.instr_memop_i, .instr_float_i, .float_group_i, .instr_divide_i, .privileged_i, .mem_addr_i,
		.mem_size_i, .access_endian_flag_i, .store_done_i, .coprocessor_result_i, .dec_valid_o,
		.dec_custom_o, .dec_memop_o, .dec_float_o, .dec_divide_o, .dec_index_o, .dec_class_o,
		.dec_nonblocking_o, .priv_fault_o, .first_operand_needed_o, .second_operand_needed_o,
		.result_writeback_o, .overflow_return_enable_o, .carry_return_enable_o, .condition_field_select_o,
		.mem_addr_o, .align_exc_o, .commit_point_signal_o, .store_data_o);
	cdr_fabric_model cdr_fabric_model_inst (.core_clk_i(core_clk_i), .rst_i(rst_i),
		.dec_custom_i(dec_custom_o), .result_o(coprocessor_result_i));

	always #2 core_clk_i = ~core_clk_i;

	////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] mkd(logic sel, logic [10:0] ext, logic [5:0] fl, logic [2:0] cr,
		logic [1:0] cls, logic [2:0] ptr, logic en);
		return {sel, ext, fl, cr, 5'h00, cls, ptr, en};
	endfunction : mkd

	task automatic bus(input logic rd, input logic wr, input logic [9:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge core_clk_i);
		cfg_rd_i <= rd; cfg_wr_i <= wr; cfg_addr_i <= a; cfg_wdata_i <= d;
		@(posedge core_clk_i);
		cfg_rd_i <= 1'h0; cfg_wr_i <= 1'h0;
		#1;
		`CHK("ack", 1'h1, cfg_ack_o)
		q = cfg_rdata_o;
	endtask : bus

	task automatic wr(input logic [9:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'h0, 1'h1, a, d, q);
	endtask : wr

	task automatic gwr(input logic [31:0] bits);
		wr(GA, bits | 32'h1);
	endtask : gwr

	task automatic rdchk(input logic [9:0] a, input logic [31:0] e, input string nm);
		logic [31:0] q;
		bus(1'h1, 1'h0, a, 32'h0, q);
		`CHK(nm, e, q)
	endtask : rdchk

	task automatic issue(input logic [31:0] ins, input logic mem, input logic flt, input logic dv,
		input logic [2:0] grp, input logic sd);
		@(posedge core_clk_i);
		instr_valid_i <= 1'h1; instr_i <= ins; instr_memop_i <= mem; instr_float_i <= flt;
		instr_divide_i <= dv; float_group_i <= grp; store_done_i <= sd;
		#1 cap = coprocessor_result_i;
		@(posedge core_clk_i);
		instr_valid_i <= 1'h0; instr_memop_i <= 1'h0; instr_float_i <= 1'h0; instr_divide_i <= 1'h0;
		store_done_i <= 1'h0;
		#1;
	endtask : issue

	////////////////////////////////////////////////////////////////////////////
	task automatic test_reset();
		rdchk(GA, ctl_tieoff_i & cdr_pkg::GEN_RW_MASK, "gen_reset");
		for (int i = 0; i < 8; i++)
			rdchk(DA, desc_tieoff_i[i] & cdr_pkg::DESC_RW_MASK, "desc_reset");
		rdchk(10'h3FF, 32'h0, "unmapped");
		wr(10'h3FF, 32'hFFFF_FFFF);
		rdchk(GA, 32'h0000_0181, "gen_after_unmapped");
		$display("test reset done");
	endtask : test_reset

	task automatic test_access();
		wr(DA, mkd(1'h1, 11'h2AA, 6'h15, 3'h3, 2'h2, 3'h2, 1'h1));
		wr(DA, mkd(1'h1, 11'h7FF, 6'h3F, 3'h7, 2'h3, 3'h2, 1'h1));
		rdchk(DA, mkd(1'h1, 11'h2AA, 6'h15, 3'h3, 2'h2, 3'h2, 1'h1), "desc2");
		rdchk(DA, desc_tieoff_i[3] & cdr_pkg::DESC_RW_MASK, "desc3");
		wr(DA, mkd(1'h0, 11'h0, 6'h0, 3'h0, 2'h3, 3'h7, 1'h0));
		rdchk(DA, desc_tieoff_i[7] & cdr_pkg::DESC_RW_MASK, "desc7");
		rdchk(DA, desc_tieoff_i[0] & cdr_pkg::DESC_RW_MASK, "ptr_wrap");
		$display("test access done");
	endtask : test_access

	task automatic test_custom();
		wr(DA, mkd(1'h1, 11'h123, 6'h00, 3'h0, 2'h0, 3'h1, 1'h0));
		wr(DA, mkd(1'h1, 11'h123, 6'h1D, 3'h5, 2'h1, 3'h3, 1'h1));
		wr(DA, mkd(1'h0, 11'h055, 6'h20, 3'h2, 2'h2, 3'h6, 1'h1));
		gwr(32'h0);
		issue({6'h04, 15'h0, 11'h123}, 1'h0, 1'h0, 1'h0, 3'h0, 1'h0);
		`CHK("hit", {1'h1, 3'h3, 2'h1}, {dec_custom_o, dec_index_o, dec_class_o})
		`CHK("attr", 8'hED, {first_operand_needed_o, second_operand_needed_o, result_writeback_o,
			overflow_return_enable_o, carry_return_enable_o, condition_field_select_o})
		issue({6'h00, 15'h0, 11'h123}, 1'h0, 1'h0, 1'h0, 3'h0, 1'h0);
		`CHK("prim_miss", 1'h0, dec_custom_o)
		issue({6'h00, 15'h0, 11'h055}, 1'h0, 1'h0, 1'h0, 3'h0, 1'h0);
		`CHK("priv_fault", 1'h1, priv_fault_o)
		@(posedge core_clk_i) privileged_i <= 1'h1;
		issue({6'h00, 15'h0, 11'h055}, 1'h0, 1'h0, 1'h0, 3'h0, 1'h0);
		`CHK("priv_ok", {1'h0, 3'h6, 2'h2, 1'h0}, {priv_fault_o, dec_index_o, dec_class_o,
			dec_nonblocking_o})
		gwr(32'h1 << cdr_pkg::G_CUSTOM_NB);
		issue({6'h00, 15'h0, 11'h055}, 1'h0, 1'h0, 1'h0, 3'h0, 1'h0);
		`CHK("force_nb", 1'h1, dec_nonblocking_o)
		gwr(32'h1 << cdr_pkg::G_CUSTOM_OFF);
		issue({6'h04, 15'h0, 11'h123}, 1'h0, 1'h0, 1'h0, 3'h0, 1'h0);
		`CHK("custom_off", 1'h0, dec_custom_o)
		issue(32'h0, 1'h1, 1'h0, 1'h0, 3'h0, 1'h0);
		`CHK("custom_off_mem", 1'h0, dec_memop_o)
		gwr(32'h1 << cdr_pkg::G_MEMOP_OFF);
		issue(32'h0, 1'h1, 1'h0, 1'h0, 3'h0, 1'h0);
		`CHK("memop_off", 1'h0, dec_memop_o)
		issue({6'h04, 15'h0, 11'h123}, 1'h0, 1'h0, 1'h0, 3'h0, 1'h0);
		`CHK("memop_off_cust", 1'h1, dec_custom_o)
		wr(GA, 32'h0);
		issue({6'h04, 15'h0, 11'h123}, 1'h0, 1'h0, 1'h0, 3'h0, 1'h0);
		`CHK("cop_off", 1'h0, dec_valid_o)
		$display("test custom done");
	endtask : test_custom

	task automatic test_memop();
		gwr((32'h1 << cdr_pkg::G_ALIGN) | (32'h1 << cdr_pkg::G_LE_TRAP) | (32'h1 << cdr_pkg::G_STORE_COMMIT)
			| (32'h1 << cdr_pkg::G_MEMOP_PRIV));
		@(posedge core_clk_i);
		privileged_i <= 1'h0; mem_addr_i <= 32'h1234_567F; mem_size_i <= 3'h3; access_endian_flag_i <= 1'h1;
		issue(32'h0, 1'h1, 1'h0, 1'h0, 3'h0, 1'h1);
		`CHK("mem_flags_a", 3'h7, {align_exc_o, commit_point_signal_o, priv_fault_o})
		`CHK("aligned", 32'h1234_5678, mem_addr_o)
		`CHK("le_data", {cap[7:0], cap[15:8], cap[23:16], cap[31:24]}, store_data_o)
		gwr((32'h1 << cdr_pkg::G_BE_TRAP) | (32'h1 << cdr_pkg::G_BE_STEER));
		@(posedge core_clk_i) access_endian_flag_i <= 1'h0;
		issue(32'h0, 1'h1, 1'h0, 1'h0, 3'h0, 1'h1);
		`CHK("mem_flags_b", 3'h4, {align_exc_o, commit_point_signal_o, priv_fault_o})
		`CHK("unaligned", 32'h1234_567F, mem_addr_o)
		`CHK("be_data", cap, store_data_o)
		$display("test memop done");
	endtask : test_memop

	task automatic test_float();
		for (int g = 0; g < 3; g++) begin
			gwr(32'h1 << (cdr_pkg::G_FCOMPLEX_OFF - g));
			issue(32'h0, 1'h0, 1'h1, 1'h0, 3'h4 >> g, 1'h0);
			`CHK("group_off", 1'h0, dec_float_o)
			issue(32'h0, 1'h0, 1'h1, 1'h0, 3'h4 >> ((g + 1) % 3), 1'h0);
			`CHK("group_on", 1'h1, dec_float_o)
		end
		gwr(32'h1 << cdr_pkg::G_FLOAT_OFF);
		issue(32'h0, 1'h0, 1'h1, 1'h0, 3'h1, 1'h0);
		`CHK("float_off", 1'h0, dec_float_o)
		gwr(32'h1 << cdr_pkg::G_FLOAT_NB);
		issue(32'h0, 1'h0, 1'h1, 1'h0, 3'h1, 1'h0);
		`CHK("float_nb", 2'h3, {dec_float_o, dec_nonblocking_o})
		gwr(32'h1 << cdr_pkg::G_DIVIDE);
		issue(32'h0, 1'h0, 1'h0, 1'h1, 3'h0, 1'h0);
		`CHK("divide_on", 1'h1, dec_divide_o)
		gwr(32'h0);
		issue(32'h0, 1'h0, 1'h0, 1'h1, 3'h0, 1'h0);
		`CHK("divide_off", 1'h0, dec_divide_o)
		$display("test float done");
	endtask : test_float

	task automatic test_reload();
		wr(DA, mkd(1'h0, 11'h7FF, 6'h3F, 3'h7, 2'h0, 3'h0, 1'h1));
		gwr(32'h0000_C000);
		wr(GA, 32'h8000_0001);
		rdchk(GA, 32'h0000_0181, "gen_reload");
		wr(DA, mkd(1'h0, 11'h0, 6'h0, 3'h0, 2'h3, 3'h0, 1'h0));
		rdchk(DA, desc_tieoff_i[0] & cdr_pkg::DESC_RW_MASK, "desc_reload");
		$display("test reload done");
	endtask : test_reload

	task automatic give_verdict();
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : give_verdict

	////////////////////////////////////////////////////////////////////////////
	initial begin
		for (int i = 0; i < 8; i++)
			desc_tieoff_i[i] = 32'h8010_07C0 | (i << 24);
		repeat (8) @(posedge core_clk_i);
		rst_i <= 1'h0;
		test_reset();
		test_access();
		test_custom();
		test_memop();
		test_float();
		test_reload();
		give_verdict();
	end

	initial begin
		repeat (20000) @(posedge core_clk_i);
		err_total++;
		$display("watchdog expired");
		give_verdict();
	end
endmodule : coprocessor_decode_config_regs_bench
